/* File: hw/otcs_pkg.sv */
/*
 * Package for the oscillator trim and clock select block: register offsets,
 * field positions, reset values, timing counts and the shared types.
 * Assumes a 10 MHz register clock and an 8-bit AXI4-Lite address.
 */
package otcs_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_TRIM   = 8'h00;  // Oscillator trim value
	localparam logic [7:0] OFS_CLOCK_SOURCE_CTRL_STAT  = 8'h04;  // Clock source control and status
	localparam logic [7:0] OFS_PROT   = 8'h08;  // Trim write enable and lock down
	localparam logic [7:0] OFS_ISTAT  = 8'h0C;  // Sticky event status, write one to clear
	localparam logic [7:0] OFS_IMASK  = 8'h10;  // Event mask
	// Clock control and status field positions
	localparam int CK_PIN_HI  = 7;  // Pin function, upper bit
	localparam int CK_PIN_LO  = 6;  // Pin function, lower bit
	localparam int CK_RSV5    = 5;  // Reserved, reads 0
	localparam int CK_SEL     = 4;  // System clock source select
	localparam int CK_IE      = 3;  // Clock switch interrupt enable
	localparam int CK_IF      = 2;  // Clock switch interrupt flag
	localparam int CK_RSV1    = 1;  // Reserved, reads 1
	localparam int CK_STA     = 0;  // Active clock status
	// Protection field positions
	localparam int PR_WE      = 0;  // Trim write enable
	localparam int PR_LOCK    = 1;  // Trim lock down
	// Event status bits
	localparam int EV_SWBACK  = 0;  // Switched back from external clock to on-chip oscillator
	localparam int EV_REFUSED = 1;  // Trim write refused
	localparam int EV_N       = 2;
	// Reset and fixed values
	localparam logic [7:0] TRIM_RST      = 8'h00;  // Trim before the factory load
	localparam logic [7:0] TRIM_READ_VAL = 8'h00;  // Value a trim read returns
	localparam logic [7:0] TRIM_SIGN_FLIP = 8'h80; // Signed to monotonic code
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Clock switch hold time and its cycle count at 10 MHz
	localparam int CLK_PERIOD_NS  = 100;
	localparam int SW_HOLD_NS     = 200;
	localparam int SW_HOLD_CYC    = (SW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] SW_HOLD_LAST = 4'(SW_HOLD_CYC - 1);
	// Clock switch sequencer states
	typedef enum logic [1:0] {SW_IDLE, SW_HALT, SW_SWAP} otcs_sw_e;
	// Decoded oscillator pin configuration
	typedef struct packed {
		logic clock_output_pin_en;     // Clock output on the second pin
		logic out_pin_hiz;   // Second pin high impedance
		logic ext_in_en;     // First pin is external clock input
		logic resonator_en;  // Both pins drive the resonator
	} otcs_pin_cfg_s;
	// Captured register write
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic       strb;
	} otcs_wcmd_s;
endpackage

/* File: hw/otcs_top.sv */
/*
 * Oscillator trim and system clock source control with an AXI4-Lite slave.
 * Assumes the clock mux obeys clk_sel_ext while clk_halt is high, and that
 * the factory trim bus is valid when reset is released.
 */
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module otcs_top
	import otcs_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic [7:0]         factory_trim,   // Factory trim data
	input  wire logic               ext_clk_fail,   // External clock lost, forces fallback
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	output logic [7:0]              osc_trim,       // Signed trim to the oscillator
	output logic [7:0]              osc_trim_code,  // Same trim as monotonic code
	output otcs_pin_cfg_s           osc_pin_cfg,    // Oscillator pin setup
	output logic                    clk_sel_ext,    // Clock mux: 1 external
	output logic                    clk_halt,       // Hold system clock during swap
	output logic                    clk_switch_irq, // Clock switch interrupt request
	output logic                    irq             // Masked sticky event interrupt
);

	// Register state
	logic [7:0]         trim_r;        // Stored trim
	logic               loaded_r;      // Factory load done
	logic               trim_we_r;     // Trim write enable
	logic               trim_lock_r;   // Trim lock down
	logic [1:0]         pin_func_r;    // Pin function field
	logic               sel_r;         // Clock source select
	logic               ie_r;          // Clock switch interrupt enable
	logic               flag_r;        // Clock switch interrupt flag
	logic               flag_seen_r;   // Flag has been read as 1
	logic               sta_r;         // Active clock status
	logic [EV_N-1:0]    istat_r;       // Sticky events
	logic [EV_N-1:0]    imask_r;       // Event mask
	// Bus capture
	logic               aw_got_r;      // Write address held
	logic               w_got_r;       // Write data held
	otcs_wcmd_s         wcmd_r;        // Captured write
	logic               wr_go;         // Perform write this cycle
	logic               wr_map;        // Write address is mapped
	// Switch sequencer
	otcs_sw_e           sw_state_r;
	logic [3:0]         sw_cnt_r;
	// Events
	logic               ev_swback;     // Switch back to on-chip completed
	logic               ev_refused;    // Trim write refused
	logic [7:0]         clock_source_ctrl_stat_rd;      // Read view of clock register
	logic [7:0]         rd_val;        // Read mux
	logic               rd_map;        // Read address is mapped

	// Write decode
	assign wr_go  = aw_got_r & w_got_r & ~s_axi_bvalid;
	assign wr_map = (wcmd_r.addr == OFS_TRIM) | (wcmd_r.addr == OFS_CLOCK_SOURCE_CTRL_STAT) | (wcmd_r.addr == OFS_PROT) |
		(wcmd_r.addr == OFS_ISTAT) | (wcmd_r.addr == OFS_IMASK);

	// Clock register read view
	always_comb begin
		clock_source_ctrl_stat_rd          = 8'h00;
		clock_source_ctrl_stat_rd[CK_PIN_HI] = pin_func_r[1];
		clock_source_ctrl_stat_rd[CK_PIN_LO] = pin_func_r[0];
		clock_source_ctrl_stat_rd[CK_RSV5] = 1'b0;
		clock_source_ctrl_stat_rd[CK_SEL]  = sel_r;
		clock_source_ctrl_stat_rd[CK_IE]   = ie_r;
		clock_source_ctrl_stat_rd[CK_IF]   = flag_r;
		clock_source_ctrl_stat_rd[CK_RSV1] = 1'b1;
		clock_source_ctrl_stat_rd[CK_STA]  = sta_r;
	end

	// Read mux
	always_comb begin
		rd_val = 8'h00;
		rd_map = 1'b1;
		case (s_axi_araddr)
			OFS_TRIM:  rd_val = TRIM_READ_VAL;
			OFS_CLOCK_SOURCE_CTRL_STAT: rd_val = clock_source_ctrl_stat_rd;
			OFS_PROT:  rd_val = {6'h00, trim_lock_r, trim_we_r};
			OFS_ISTAT: rd_val = {6'h00, istat_r};
			OFS_IMASK: rd_val = {6'h00, imask_r};
			default:   rd_map = 1'b0;
		endcase
	end

	// Write channel capture, address and data in either order
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aw_got_r      <= 1'b0;
			w_got_r       <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			wcmd_r        <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r      <= 1'b1;
				s_axi_awready <= 1'b0;
				wcmd_r.addr   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r      <= 1'b1;
				s_axi_wready <= 1'b0;
				wcmd_r.data  <= s_axi_wdata[7:0];
				wcmd_r.strb  <= s_axi_wstrb[0];
			end
			// Reopen both channels once the response is taken
			if (s_axi_bvalid && s_axi_bready) begin
				aw_got_r      <= 1'b0;
				w_got_r       <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Write response
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read channel, answer in the cycle after the address is taken
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rd_val};
			s_axi_rresp   <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Trim register: factory load after reset, then guarded writes
	assign ev_refused = wr_go && wcmd_r.strb && wcmd_r.addr == OFS_TRIM && (!trim_we_r || trim_lock_r);
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			trim_r   <= TRIM_RST;
			loaded_r <= 1'b0;
		end else if (!loaded_r) begin
			trim_r   <= factory_trim;
			loaded_r <= 1'b1;
		end else if (wr_go && wcmd_r.strb && wcmd_r.addr == OFS_TRIM && trim_we_r && !trim_lock_r) begin
			trim_r   <= wcmd_r.data;
		end
	end

	// Trim drive, a direct copy so a write lands the next cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			osc_trim      <= TRIM_RST;
			osc_trim_code <= TRIM_RST ^ TRIM_SIGN_FLIP;
		end else begin
			osc_trim      <= trim_r;
			osc_trim_code <= trim_r ^ TRIM_SIGN_FLIP;
		end
	end

	// Trim protection; lock sticks until reset
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			trim_we_r   <= 1'b0;
			trim_lock_r <= 1'b0;
		end else if (wr_go && wcmd_r.strb && wcmd_r.addr == OFS_PROT) begin
			trim_we_r   <= wcmd_r.data[PR_WE];
			trim_lock_r <= trim_lock_r | wcmd_r.data[PR_LOCK];
		end
	end

	// Pin function field and its registered decode
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pin_func_r  <= 2'h0;
			osc_pin_cfg <= '0;
		end else if (wr_go && wcmd_r.strb && wcmd_r.addr == OFS_CLOCK_SOURCE_CTRL_STAT) begin
			pin_func_r  <= wcmd_r.data[CK_PIN_HI:CK_PIN_LO];
			// 00 general I/O, 10 clock out, 01 ext input, 11 resonator
			osc_pin_cfg.clock_output_pin_en    <= wcmd_r.data[CK_PIN_HI] & ~wcmd_r.data[CK_PIN_LO];
			osc_pin_cfg.out_pin_hiz  <= ~wcmd_r.data[CK_PIN_HI] & wcmd_r.data[CK_PIN_LO];
			osc_pin_cfg.ext_in_en    <= ~wcmd_r.data[CK_PIN_HI] & wcmd_r.data[CK_PIN_LO];
			osc_pin_cfg.resonator_en <= wcmd_r.data[CK_PIN_HI] & wcmd_r.data[CK_PIN_LO];
		end
	end

	// Source select and interrupt enable
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sel_r <= 1'b0;
			ie_r  <= 1'b0;
		end else begin
			if (wr_go && wcmd_r.strb && wcmd_r.addr == OFS_CLOCK_SOURCE_CTRL_STAT) begin
				ie_r <= wcmd_r.data[CK_IE];
				if (!wcmd_r.data[CK_SEL])
					sel_r <= 1'b0;
				else if (!flag_r)
					sel_r <= 1'b1;
			end
			// Lost external clock drops the selection back
			if (ext_clk_fail)
				sel_r <= 1'b0;
		end
	end

	// Glitch-free switch: halt, wait, swap mux, wait, release; report only a switch back to on-chip
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sw_state_r  <= SW_IDLE;
			sw_cnt_r    <= 4'h0;
			clk_halt    <= 1'b0;
			clk_sel_ext <= 1'b0;
			sta_r       <= 1'b0;
		end else begin
			case (sw_state_r)
				SW_IDLE: begin
					if (sel_r != sta_r) begin
						clk_halt   <= 1'b1;
						sw_cnt_r   <= 4'h0;
						sw_state_r <= SW_HALT;
					end
				end
				SW_HALT: begin
					// Clock held low before the mux moves
					if (sw_cnt_r == SW_HOLD_LAST) begin
						clk_sel_ext <= ~sta_r;
						sw_cnt_r    <= 4'h0;
						sw_state_r  <= SW_SWAP;
					end else begin
						sw_cnt_r <= sw_cnt_r + 4'h1;
					end
				end
				SW_SWAP: begin
					// New source settles before the clock is released
					if (sw_cnt_r == SW_HOLD_LAST) begin
						clk_halt   <= 1'b0;
						sta_r      <= clk_sel_ext;
						sw_state_r <= SW_IDLE;
					end else begin
						sw_cnt_r <= sw_cnt_r + 4'h1;
					end
				end
				default: sw_state_r <= SW_IDLE;
			endcase
		end
	end
	assign ev_swback = (sw_state_r == SW_SWAP) && (sw_cnt_r == SW_HOLD_LAST) && sta_r && !clk_sel_ext;

	// Clock switch flag: set wins over clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flag_r      <= 1'b0;
			flag_seen_r <= 1'b0;
		end else begin
			if (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CLOCK_SOURCE_CTRL_STAT && flag_r)
				flag_seen_r <= 1'b1;
			if (ev_swback) begin
				flag_r <= 1'b1;
			end else if (wr_go && wcmd_r.strb && wcmd_r.addr == OFS_CLOCK_SOURCE_CTRL_STAT && !wcmd_r.data[CK_IF] && flag_seen_r) begin
				flag_r      <= 1'b0;
				flag_seen_r <= 1'b0;
			end
		end
	end

	// Sticky event status and mask
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			istat_r <= '0;
			imask_r <= '0;
		end else begin
			if (wr_go && wcmd_r.strb && wcmd_r.addr == OFS_ISTAT)
				istat_r <= istat_r & ~wcmd_r.data[EV_N-1:0];
			if (wr_go && wcmd_r.strb && wcmd_r.addr == OFS_IMASK)
				imask_r <= wcmd_r.data[EV_N-1:0];
			if (ev_swback)
				istat_r[EV_SWBACK] <= 1'b1;
			if (ev_refused)
				istat_r[EV_REFUSED] <= 1'b1;
		end
	end

	// Interrupt outputs, registered from current state
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			clk_switch_irq <= 1'b0;
			irq            <= 1'b0;
		end else begin
			clk_switch_irq <= flag_r & ie_r;
			irq            <= |(istat_r & imask_r);
		end
	end

endmodule // otcs_top

/* File: testbench/otcs_assertions.sv */
/*
 * Port-level checker for the oscillator trim and clock select block.
 * Assumes it is bound to otcs_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module otcs_assertions
	import otcs_pkg::*;
(
	input wire logic          clock,
	input wire logic          arst_n,
	input wire logic [7:0]    factory_trim,
	input wire logic          ext_clk_fail,
	input wire logic          s_axi_awvalid,
	input wire logic          s_axi_awready,
	input wire logic          s_axi_wvalid,
	input wire logic          s_axi_wready,
	input wire logic          s_axi_bvalid,
	input wire logic [7:0]    s_axi_araddr,
	input wire logic          s_axi_arvalid,
	input wire logic          s_axi_arready,
	input wire logic [31:0]   s_axi_rdata,
	input wire logic          s_axi_rvalid,
	input wire logic [7:0]    osc_trim,
	input wire logic [7:0]    osc_trim_code,
	input wire otcs_pin_cfg_s osc_pin_cfg,
	input wire logic          clk_sel_ext,
	input wire logic          clk_halt
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [1:0] rel_r;  // Edges since reset release, saturating
	// Counts edges so the factory load moment can be pinned down
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) rel_r <= 2'h0;
		else if (rel_r != 2'h3) rel_r <= rel_r + 2'h1;
	end
	// Halt stays up for at least the first three cycles of the swap
	sequence s_swap_hold;
		clk_halt[*3];
	endsequence
	a_factory_load: assert property (rel_r == 2'h2 |-> osc_trim == factory_trim)
		else $error("factory trim not loaded");
	a_trim_signed: assert property (osc_trim_code == (osc_trim ^ TRIM_SIGN_FLIP))
		else $error("trim code not sign flipped");
	a_trim_read_blank: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_TRIM
		|=> s_axi_rdata == {24'h0, TRIM_READ_VAL}) else $error("trim read shows data");
	a_pin_decode: assert property ($onehot0({osc_pin_cfg.clock_output_pin_en, osc_pin_cfg.ext_in_en,
		osc_pin_cfg.resonator_en}) && osc_pin_cfg.ext_in_en == osc_pin_cfg.out_pin_hiz)
		else $error("pin setup inconsistent");
	a_sel_in_halt: assert property ($changed(clk_sel_ext) |-> clk_halt && $past(clk_halt))
		else $error("source moved outside halt");
	a_halt_bounded: assert property ($rose(clk_halt) |-> s_swap_hold ##[1:6] !clk_halt)
		else $error("halt length wrong");
	a_fail_fallback: assert property (ext_clk_fail && clk_sel_ext |-> ##[1:8] !clk_sel_ext)
		else $error("no fallback on clock loss");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
endmodule // otcs_assertions

bind otcs_top otcs_assertions u_chk (.clock, .arst_n, .factory_trim, .ext_clk_fail, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .osc_trim, .osc_trim_code, .osc_pin_cfg,
	.clk_sel_ext, .clk_halt);

/* File: testbench/tb_top.sv */
/*
 * Self-checking bench for the oscillator trim and clock select block.
 * Assumes otcs_top and otcs_pkg are compiled first; one 10 MHz clock.
 */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top
	import otcs_pkg::*;
;
	logic          clock, arst_n, ext_clk_fail;
	logic [7:0]    factory_trim, s_axi_awaddr, s_axi_araddr, osc_trim, osc_trim_code, v;
	logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic          s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0]   s_axi_wdata, s_axi_rdata, d;
	logic [3:0]    s_axi_wstrb;
	logic [1:0]    s_axi_bresp, s_axi_rresp, rsp, rrsp;
	otcs_pin_cfg_s osc_pin_cfg;
	logic          clk_sel_ext, clk_halt, clk_switch_irq, irq;
	int            bad_count, checks_done, seed, i;
	otcs_top i_dut (.*);
	// Expected pin setup for a pin field value
	function automatic logic [3:0] pin_exp(input logic [1:0] p);
		case (p)
			2'b00: return 4'h0;
			2'b10: return 4'h8;
			2'b01: return 4'h6;
			default: return 4'h1;
		endcase
	endfunction
	// Monotonic code of a signed trim
	function automatic logic [7:0] code_exp(input logic [7:0] t);
		return {~t[7], t[6:0]};
	endfunction
	// One AXI4-Lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clock);
		s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= x; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// One AXI4-Lite read
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		rrsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Verdict and end of run
	task automatic stop_test();
		if (bad_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Free running 10 MHz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Cuts a hung run short
	initial begin
		repeat (5000) @(posedge clock);
		bad_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		seed = 86; arst_n = 1'b0; ext_clk_fail = 1'b0; factory_trim = 8'($random(seed));
		s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("trim", factory_trim, osc_trim)
		`CHK("code", code_exp(factory_trim), osc_trim_code)
		rd(OFS_TRIM); `CHK("trim_rd", 32'h0, d)
		`CHK("rd_ok", RESP_OKAY, rrsp)
		// Trim write while not enabled is refused and raises an event
		wr(OFS_TRIM, 32'h55); repeat (2) @(posedge clock); `CHK("refused", factory_trim, osc_trim)
		wr(OFS_IMASK, 32'h2); repeat (2) @(posedge clock); `CHK("irq", 1'b1, irq)
		`CHK("wr_ok", RESP_OKAY, rsp)
		wr(OFS_ISTAT, 32'h2); repeat (2) @(posedge clock); `CHK("irq_clr", 1'b0, irq)
		wr(OFS_PROT, 32'h1);
		// Extremes first, then random trims
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($random(seed));
			wr(OFS_TRIM, {24'h0, v}); repeat (2) @(posedge clock);
			`CHK("trim_wr", v, osc_trim)
			`CHK("code_wr", code_exp(v), osc_trim_code)
		end
		wr(OFS_PROT, 32'h3); wr(OFS_TRIM, {24'h0, ~v}); repeat (2) @(posedge clock);
		`CHK("lock", v, osc_trim)
		rd(OFS_CLOCK_SOURCE_CTRL_STAT); `CHK("ck_rst", 32'h2, d)
		// Every pin mode, with the reserved bits written against their fixed values
		for (i = 0; i < 4; i++) begin
			wr(OFS_CLOCK_SOURCE_CTRL_STAT, {24'h0, i[1:0], 6'h20}); repeat (2) @(posedge clock);
			`CHK("pins", pin_exp(i[1:0]), osc_pin_cfg)
			rd(OFS_CLOCK_SOURCE_CTRL_STAT); `CHK("ck_rsv", {i[1:0], 6'h02}, d[7:0] & 8'hE2)
		end
		// Switch to external and back with the interrupt enabled
		wr(OFS_CLOCK_SOURCE_CTRL_STAT, 32'hD8); repeat (8) @(posedge clock); `CHK("sel_ext", 1'b1, clk_sel_ext)
		rd(OFS_CLOCK_SOURCE_CTRL_STAT); `CHK("ck_ext", 5'h1B, d[4:0])
		wr(OFS_CLOCK_SOURCE_CTRL_STAT, 32'hC8); repeat (8) @(posedge clock); `CHK("sel_osc", 1'b0, clk_sel_ext)
		`CHK("sw_irq", 1'b1, clk_switch_irq)
		rd(OFS_CLOCK_SOURCE_CTRL_STAT); `CHK("ck_back", 5'h0E, d[4:0])
		// Select refused while the flag is set
		wr(OFS_CLOCK_SOURCE_CTRL_STAT, 32'hDC); repeat (8) @(posedge clock); `CHK("sel_held", 1'b0, clk_sel_ext)
		wr(OFS_CLOCK_SOURCE_CTRL_STAT, 32'hC8); repeat (2) @(posedge clock); `CHK("irq_off", 1'b0, clk_switch_irq)
		// Clock loss fallback with the interrupt masked
		wr(OFS_CLOCK_SOURCE_CTRL_STAT, 32'hD0); repeat (8) @(posedge clock);
		ext_clk_fail <= 1'b1; repeat (10) @(posedge clock); ext_clk_fail <= 1'b0;
		`CHK("fail_sel", 1'b0, clk_sel_ext)
		`CHK("masked", 1'b0, clk_switch_irq)
		wr(OFS_CLOCK_SOURCE_CTRL_STAT, 32'hCC); repeat (2) @(posedge clock); `CHK("unmask", 1'b1, clk_switch_irq)
		// Unmapped address
		wr(8'h40, 32'hFF); `CHK("bad_wr", RESP_SLVERR, rsp)
		rd(8'h40); `CHK("bad_rd", 32'h0, d)
		`CHK("bad_rresp", RESP_SLVERR, rrsp)
		// Write with byte lane 0 disabled leaves the mask alone
		s_axi_wstrb <= 4'h0;
		wr(OFS_IMASK, 32'h0);
		s_axi_wstrb <= 4'hF;
		rd(OFS_IMASK); `CHK("strb_off", 32'h2, d)
		stop_test();
	end
endmodule // tb_top
